/* logic/brk_pkg.sv */
package brk_pkg;
  // Byte offsets of the three registers on the bus.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_TRACE = 8'h08;
  // Field positions in break_control.
  localparam int B_ASM_A = 21;
  localparam int B_ASM_B = 20;
  localparam int B_CA    = 15;
  localparam int B_CB    = 14;
  localparam int B_DA    = 13;
  localparam int B_DB    = 12;
  localparam int B_TE    = 11;
  localparam int B_AEA   = 10;
  localparam int B_DBE   = 7;
  localparam int B_AEB   = 6;
  localparam int B_SEQ   = 3;
  localparam int B_EXEC_COUNT_ENABLE  = 0;
  // Field position in branch_source_trace, counter width, queue depth and counter constants.
  localparam int B_VALID = 31;
  localparam int CW      = 12;
  localparam int QDEPTH  = 8;
  localparam logic [CW-1:0] CNT_ONE  = 12'h001;
  localparam logic [CW-1:0] CNT_ZERO = 12'h000;
  // Break type codes sent to the core.
  localparam logic [1:0] BT_DATA = 2'h0;
  localparam logic [1:0] BT_PRE  = 2'h1;
  localparam logic [1:0] BT_POST = 2'h2;
  // Selection codes of the bus cycle select fields.
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_ONE  = 2'h1;
  localparam logic [1:0] SEL_TWO  = 2'h2;
endpackage : brk_pkg

/* logic/break_control_branch_trace.sv */
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module break_control_branch_trace
  import brk_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        manual_resetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Observed bus cycle.
  input  wire logic        cyc_valid,
  input  wire logic        cyc_dma,
  input  wire logic        cyc_fetch,
  input  wire logic        cyc_write,
  // Comparator results and cycle selections.
  input  wire logic        addr_hit_a,
  input  wire logic        addr_hit_b,
  input  wire logic        asid_hit_a,
  input  wire logic        asid_hit_b,
  input  wire logic        data_hit_b,
  input  wire logic [5:0]  bus_cycle_select_a,
  input  wire logic [5:0]  bus_cycle_select_b,
  // Branch source from the core.
  input  wire logic        branch,
  input  wire logic [27:0] branch_origin_address,
  input  wire logic [2:0]  decode_pointer,
  // Break request.
  output logic             break_req,
  output logic [1:0]       break_type
);

  typedef struct packed {
    logic                        asid_mask_a;
    logic                        asid_mask_b;
    logic                        cpu_match_flag_a;
    logic                        cpu_match_flag_b;
    logic                        dma_match_flag_a;
    logic                        dma_match_flag_b;
    logic                        trace_enable;
    logic                        after_exec_select_a;
    logic                        data_compare_enable_b;
    logic                        after_exec_select_b;
    logic                        chained_channel_mode;
    logic                        exec_count_enable;
    logic [CW-1:0]               count;
    logic [QDEPTH-1:0][31:0]     queue;
    logic                        a_seen;
    logic                        wr_pend;
    logic                        rd_pend;
    logic [7:0]                  addr;
    logic                        hreadyout;
    logic [31:0]                 hrdata;
    logic                        break_req;
    logic [1:0]                  break_type;
  } state_t;

  state_t r;
  state_t next_r;

  // Cycle select match: cycle type, fetch/data, read/write groups.
  function automatic logic sel_ok(input logic [5:0] s, input logic dma, input logic fet, input logic wr);
    logic cd;
    logic id;
    logic rw;
    cd = dma ? (s[5:4] == SEL_TWO) : s[4];
    id = fet ? s[2] : s[3];
    rw = wr ? s[1] : s[0];
    sel_ok = cd & id & rw;
  endfunction : sel_ok

  logic cond_a;
  logic cond_b;
  logic brk_a;
  logic brk_b;
  logic seq_ok;
  logic cnt_ok;
  logic acc;
  logic wr_ctrl;
  logic rd_trace;
  logic [31:0] ctrl_word;

  // Channel conditions; a 00 group never matches.
  always_comb begin
    cond_a = cyc_valid & addr_hit_a & sel_ok(bus_cycle_select_a, cyc_dma, cyc_fetch, cyc_write)
             & (r.asid_mask_a | asid_hit_a);
    cond_b = cyc_valid & addr_hit_b & sel_ok(bus_cycle_select_b, cyc_dma, cyc_fetch, cyc_write)
             & (r.asid_mask_b | asid_hit_b)
             & (~r.data_compare_enable_b | cyc_fetch | data_hit_b);
    seq_ok = ~r.chained_channel_mode | r.a_seen;
    cnt_ok = ~r.exec_count_enable | (r.count == CNT_ONE);
    brk_a  = cond_a & ~r.chained_channel_mode;
    brk_b  = cond_b & seq_ok & cnt_ok;
  end

  // Bus decode and the control word image; unused bits stay zero.
  always_comb begin
    acc      = hsel & htrans[1] & hready;
    wr_ctrl  = r.wr_pend & (r.addr == OFS_CTRL);
    rd_trace = r.rd_pend & (r.addr == OFS_TRACE);
    ctrl_word = 32'h0000_0000;
    ctrl_word[B_ASM_A] = r.asid_mask_a;
    ctrl_word[B_ASM_B] = r.asid_mask_b;
    ctrl_word[B_CA]    = r.cpu_match_flag_a;
    ctrl_word[B_CB]    = r.cpu_match_flag_b;
    ctrl_word[B_DA]    = r.dma_match_flag_a;
    ctrl_word[B_DB]    = r.dma_match_flag_b;
    ctrl_word[B_TE]    = r.trace_enable;
    ctrl_word[B_AEA]   = r.after_exec_select_a;
    ctrl_word[B_DBE]   = r.data_compare_enable_b;
    ctrl_word[B_AEB]   = r.after_exec_select_b;
    ctrl_word[B_SEQ]   = r.chained_channel_mode;
    ctrl_word[B_EXEC_COUNT_ENABLE]  = r.exec_count_enable;
  end

  // Next state. Reads take one wait state so a write just before is seen.
  always_comb begin
    next_r = r;
    next_r.wr_pend   = acc & hwrite;
    next_r.rd_pend   = acc & ~hwrite;
    next_r.hreadyout = ~(acc & ~hwrite);
    if (acc) begin
      next_r.addr = haddr;
    end
    // Register writes in the data phase.
    if (wr_ctrl) begin
      next_r.asid_mask_a           = hwdata[B_ASM_A];
      next_r.asid_mask_b           = hwdata[B_ASM_B];
      next_r.trace_enable          = hwdata[B_TE];
      next_r.after_exec_select_a   = hwdata[B_AEA];
      next_r.data_compare_enable_b = hwdata[B_DBE];
      next_r.after_exec_select_b   = hwdata[B_AEB];
      next_r.chained_channel_mode  = hwdata[B_SEQ];
      next_r.exec_count_enable     = hwdata[B_EXEC_COUNT_ENABLE];
      // Writing one keeps a flag; writing zero clears it.
      next_r.cpu_match_flag_a = r.cpu_match_flag_a & hwdata[B_CA];
      next_r.cpu_match_flag_b = r.cpu_match_flag_b & hwdata[B_CB];
      next_r.dma_match_flag_a = r.dma_match_flag_a & hwdata[B_DA];
      next_r.dma_match_flag_b = r.dma_match_flag_b & hwdata[B_DB];
    end
    if (r.wr_pend & (r.addr == OFS_COUNT)) begin
      next_r.count = hwdata[CW-1:0];
    end
    // Hardware setting of the flags wins over a clear in the same cycle.
    if (cond_a & ~cyc_dma) next_r.cpu_match_flag_a = 1'b1;
    if (cond_b & ~cyc_dma) next_r.cpu_match_flag_b = 1'b1;
    if (cond_a & cyc_dma)  next_r.dma_match_flag_a = 1'b1;
    if (cond_b & cyc_dma)  next_r.dma_match_flag_b = 1'b1;
    // Chaining: remember an A match until B completes the sequence.
    if (r.chained_channel_mode & cond_a) begin
      next_r.a_seen = 1'b1;
    end
    if (~r.chained_channel_mode | brk_b) begin
      next_r.a_seen = r.chained_channel_mode & cond_a & ~cond_b;
    end
    // Counter steps down on each channel B match that the chain sequence allows and sticks at zero.
    if (r.exec_count_enable & cond_b & seq_ok & (r.count != CNT_ZERO)) begin
      next_r.count = r.count - CNT_ONE;
    end
    // Break request and type; channel A takes precedence for the type.
    next_r.break_req  = brk_a | brk_b;
    next_r.break_type = BT_DATA;
    if (cyc_fetch) begin
      next_r.break_type = (brk_a ? r.after_exec_select_a : r.after_exec_select_b)
                          ? BT_POST : BT_PRE;
    end
    // Read data mux, loaded in the wait state.
    if (r.rd_pend) begin
      case (r.addr)
        OFS_CTRL:  next_r.hrdata = ctrl_word;
        OFS_COUNT: next_r.hrdata = {20'h00000, r.count};
        OFS_TRACE: next_r.hrdata = r.queue[0];
        default:   next_r.hrdata = 32'h0000_0000;
      endcase
    end
    // Reading the head entry clears its valid flag.
    if (rd_trace) begin
      next_r.queue[0][B_VALID] = 1'b0;
    end
    // Capture pointer and address; software decodes an odd pointer as plus two.
    if (branch & r.trace_enable) begin
      for (int i = QDEPTH - 1; i > 0; i--) begin
        next_r.queue[i] = r.queue[i-1];
      end
      if (rd_trace) begin
        next_r.queue[1][B_VALID] = 1'b0;
      end
      next_r.queue[0] = {1'b1, decode_pointer, branch_origin_address};
    end
    // Manual reset clears only the valid flags.
    if (~manual_resetn) begin
      for (int i = 0; i < QDEPTH; i++) begin
        next_r.queue[i][B_VALID] = 1'b0;
      end
    end
  end

  // State register; power-on reset clears everything including the counter, but sets hreadyout.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hreadyout <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops; response is always OKAY.
  always_comb begin
    hreadyout  = r.hreadyout;
    hresp      = 1'b0;
    hrdata     = r.hrdata;
    break_req  = r.break_req;
    break_type = r.break_type;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_capture;
    branch & r.trace_enable & manual_resetn;
  endsequence
  sequence s_last_count;
    cond_b & r.exec_count_enable & ~r.chained_channel_mode & (r.count == CNT_ONE);
  endsequence

  a_flag_cpu_a: assert property (cond_a & ~cyc_dma |=> r.cpu_match_flag_a)
    else $error("cpu flag a not set");
  a_flag_cpu_b: assert property (cond_b & ~cyc_dma |=> r.cpu_match_flag_b)
    else $error("cpu flag b not set");
  a_flag_dma_a: assert property (cond_a & cyc_dma |=> r.dma_match_flag_a)
    else $error("dma flag a not set");
  a_flag_dma_b: assert property (cond_b & cyc_dma |=> r.dma_match_flag_b)
    else $error("dma flag b not set");
  a_flag_sticky: assert property (r.cpu_match_flag_a & ~wr_ctrl |=> r.cpu_match_flag_a)
    else $error("flag dropped without write");
  a_count_break: assert property (s_last_count |=> break_req && (r.count == CNT_ZERO))
    else $error("counted break missing");
  a_count_step: assert property (cond_b & r.exec_count_enable & ~r.chained_channel_mode
    & ~r.wr_pend & (r.count != CNT_ZERO) |=> r.count == $past(r.count) - CNT_ONE)
    else $error("counter did not step");
  a_trace_hold: assert property (~r.trace_enable & ~r.rd_pend & manual_resetn |=> $stable(r.queue))
    else $error("trace changed while off");
  a_trace_valid: assert property (s_capture |=> r.queue[0][B_VALID])
    else $error("capture not valid");
  a_no_compare: assert property ((bus_cycle_select_a[5:4] == SEL_NONE) & (bus_cycle_select_b[5:4] == SEL_NONE)
    |=> !break_req)
    else $error("break with no compare");

  // Writable bits of the control word; everything else must read back as zero.
  localparam logic [31:0] CTRL_MASK = 32'h0030_fcc9;

  // A data phase on the control register is followed by a clean word.
  sequence s_ctrl_read;
    r.rd_pend & (r.addr == OFS_CTRL);
  endsequence
  // A data phase on the counter is followed by a word with the top bits clear.
  sequence s_count_read;
    r.rd_pend & (r.addr == OFS_COUNT);
  endsequence
  // A fetch break that channel A owns.
  sequence s_fetch_a;
    brk_a & cyc_fetch;
  endsequence
  // A fetch break that only channel B owns.
  sequence s_fetch_b;
    brk_b & ~brk_a & cyc_fetch;
  endsequence

  // With the mask clear, a missing ASID hit on A must keep the request low.
  a_asid_check_a: assert property (cyc_valid & ~asid_hit_a & ~r.asid_mask_a & ~cond_b |=> !break_req)
    else $error("asid a ignored");
  // Same for channel B.
  a_asid_check_b: assert property (cyc_valid & ~asid_hit_b & ~r.asid_mask_b & ~cond_a |=> !break_req)
    else $error("asid b ignored");
  // Reserved control bits never leak into read data.
  a_ctrl_reserved: assert property (s_ctrl_read |=> (hrdata & ~CTRL_MASK) == 32'h0000_0000)
    else $error("reserved control bit set");
  // The counter is only twelve bits wide on the bus.
  a_count_upper: assert property (s_count_read |=> hrdata[31:CW] == '0)
    else $error("counter upper bits set");
  // With counting masked only a bus write may move the counter.
  a_count_idle: assert property (~r.exec_count_enable & ~r.wr_pend |=> $stable(r.count))
    else $error("counter moved while masked");
  // While counting, channel B stays silent until the counter holds one.
  a_count_gate: assert property (cond_b & ~cond_a & r.exec_count_enable & (r.count != CNT_ONE)
    |=> !break_req)
    else $error("counted break too early");
  // Channel A fetch break before execution.
  a_type_pre_a: assert property (s_fetch_a & ~r.after_exec_select_a |=> break_type == BT_PRE)
    else $error("channel a pre type wrong");
  // Channel A fetch break after execution.
  a_type_post_a: assert property (s_fetch_a & r.after_exec_select_a |=> break_type == BT_POST)
    else $error("channel a post type wrong");
  // Channel B fetch break before execution.
  a_type_pre_b: assert property (s_fetch_b & ~r.after_exec_select_b |=> break_type == BT_PRE)
    else $error("channel b pre type wrong");
  // Channel B fetch break after execution.
  a_type_post_b: assert property (s_fetch_b & r.after_exec_select_b |=> break_type == BT_POST)
    else $error("channel b post type wrong");
  // A break on a data access reports the data type.
  a_type_data: assert property ((brk_a | brk_b) & ~cyc_fetch |=> break_type == BT_DATA)
    else $error("data type wrong");
  // Every satisfied channel raises the request on the next edge.
  a_req_raise: assert property (brk_a | brk_b |=> break_req)
    else $error("request missing");
  // And nothing else raises it, so the pulse lasts one cycle per match.
  a_req_quiet: assert property (!(brk_a | brk_b) |=> !break_req)
    else $error("spurious request");
  // In chained mode channel A alone never breaks.
  a_chain_quiet: assert property (r.chained_channel_mode & ~cond_b |=> !break_req)
    else $error("chained a broke alone");
  // A data access that misses the data compare cannot break channel B.
  a_data_gate: assert property (cyc_valid & ~cyc_fetch & r.data_compare_enable_b & ~data_hit_b & ~cond_a
    |=> !break_req)
    else $error("data compare ignored");
  // A capture pushes the old head one place down.
  a_trace_shift: assert property (s_capture |=> r.queue[1][30:0] == $past(r.queue[0][30:0]))
    else $error("queue did not shift");
  // The new head holds the pointer above the address.
  a_trace_entry: assert property (s_capture
    |=> r.queue[0][30:0] == $past({decode_pointer, branch_origin_address}))
    else $error("entry contents wrong");
  // Reading the head clears its valid flag when no capture coincides.
  a_trace_read: assert property (rd_trace & ~(branch & r.trace_enable) |=> !r.queue[0][B_VALID])
    else $error("valid not cleared by read");
  // Manual reset drops the valid flags at both ends of the queue.
  a_manual_clear: assert property (~manual_resetn
    |=> !r.queue[0][B_VALID] && !r.queue[QDEPTH-1][B_VALID])
    else $error("valid kept through manual reset");
  // A match and a software clear in one cycle leave the flag set.
  a_set_wins: assert property (cond_a & ~cyc_dma & wr_ctrl & ~hwdata[B_CA] |=> r.cpu_match_flag_a)
    else $error("clear beat set");
  // Writing one to a set flag keeps it.
  a_keep_one: assert property (r.cpu_match_flag_b & wr_ctrl & hwdata[B_CB] |=> r.cpu_match_flag_b)
    else $error("flag lost on written one");
  // A read inserts exactly one wait state, then the data phase ends.
  a_read_wait: assert property (acc & ~hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  // The response is always OKAY.
  a_resp_okay: assert property (!hresp)
    else $error("error response");

endmodule : break_control_branch_trace

/* tb/bus_cycle_source.sv */
`timescale 1ns/1ps
// Stands in for the core and the DMA controller whose cycles the break unit watches.
module bus_cycle_source (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Requests from the bench.
  input  wire logic        go,
  input  wire logic [2:0]  kind,
  input  wire logic [4:0]  hits,
  input  wire logic        br_go,
  input  wire logic [30:0] br_info,
  // Cycle as the break unit sees it.
  output logic             cyc_valid,
  output logic [2:0]       cyc_kind,
  output logic [4:0]       cyc_hits,
  output logic             branch,
  output logic [30:0]      br_word
);
  // Each request stands one cycle; between requests the qualifiers flip every cycle,
  // so logic that looks at them outside a valid cycle cannot pass by luck.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_valid <= 1'b0;
      cyc_kind  <= 3'h0;
      cyc_hits  <= 5'h00;
      branch    <= 1'b0;
      br_word   <= 31'h0;
    end else begin
      cyc_valid <= go;
      cyc_kind  <= go ? kind : ~cyc_kind;
      cyc_hits  <= go ? hits : ~cyc_hits;
      branch    <= br_go;
      br_word   <= br_go ? br_info : ~br_word;
    end
  end
endmodule : bus_cycle_source

/* tb/break_control_branch_trace_tb_top.sv */
`timescale 1ns/1ps
module break_control_branch_trace_tb_top;
  import brk_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [5:0]  sa;
    logic [5:0]  sb;
    logic [2:0]  kind;
    logic [4:0]  hits;
    logic        req;
    logic [1:0]  typ;
    logic [3:0]  flags;
  } row_t;
  // Bench-driven signals, all defined at time zero.
  logic        hclk = 1'b0, hresetn = 1'b0, mrst_n = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic [5:0]  sa = 6'h00, sb = 6'h00;
  logic        go = 1'b0, br_go = 1'b0, hreadyout, cyc_valid, branch, break_req;
  logic [2:0]  kind = 3'h0, ck;
  logic [4:0]  hits = 5'h00, ch;
  logic [30:0] br_info = 31'h0, bw;
  logic [1:0]  break_type;
  int          mismatches = 0, comparisons = 0;
  row_t        rows[$];
  localparam logic [5:0] C = 6'h1f, D = 6'h2f;
  always #5 hclk = ~hclk;
  bus_cycle_source far (.hclk(hclk), .hresetn(hresetn), .go(go), .kind(kind), .hits(hits), .br_go(br_go),
    .br_info(br_info), .cyc_valid(cyc_valid), .cyc_kind(ck), .cyc_hits(ch), .branch(branch), .br_word(bw));
  break_control_branch_trace dut (.hclk(hclk), .hresetn(hresetn), .manual_resetn(mrst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .cyc_valid(cyc_valid), .cyc_dma(ck[2]),
    .cyc_fetch(ck[1]), .cyc_write(ck[0]), .addr_hit_a(ch[4]), .addr_hit_b(ch[3]), .asid_hit_a(ch[2]),
    .asid_hit_b(ch[1]), .data_hit_b(ch[0]), .bus_cycle_select_a(sa), .bus_cycle_select_b(sb),
    .branch(branch), .branch_origin_address(bw[27:0]), .decode_pointer(bw[30:28]),
    .break_req(break_req), .break_type(break_type));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // The wait is bounded so that a slave that never answers ends the run.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus
  task automatic fire(input logic [2:0] k, input logic [4:0] h);
    @(posedge hclk);
    go   <= 1'b1;
    kind <= k;
    hits <= h;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    #1;
  endtask : fire
  task automatic brf(input logic [30:0] b);
    @(posedge hclk);
    br_go   <= 1'b1;
    br_info <= b;
    @(posedge hclk);
    br_go <= 1'b0;
  endtask : brf
  task automatic add(input logic [31:0] c, input logic [5:0] a, input logic [2:0] k,
                     input logic [4:0] h, input logic r, input logic [1:0] t, input logic [3:0] f);
    rows.push_back(row_t'{c, a, C, k, h, r, t, f});
  endtask : add
  initial begin
    add(32'h0, C, 3'h0, 5'h14, 1'b1, BT_DATA, 4'h8);
    add(32'h0, C, 3'h0, 5'h0a, 1'b1, BT_DATA, 4'h4);
    add(32'h0, D, 3'h4, 5'h14, 1'b1, BT_DATA, 4'h2);
    add(32'h0, D, 3'h4, 5'h0b, 1'b1, BT_DATA, 4'h1);
    add(32'h0, C, 3'h0, 5'h10, 1'b0, BT_DATA, 4'h0);
    add(32'h00200000, C, 3'h0, 5'h10, 1'b1, BT_DATA, 4'h8);
    add(32'h0, C, 3'h0, 5'h08, 1'b0, BT_DATA, 4'h0);
    add(32'h00100000, C, 3'h0, 5'h08, 1'b1, BT_DATA, 4'h4);
    add(32'h80, C, 3'h0, 5'h0a, 1'b0, BT_DATA, 4'h0);
    add(32'h80, C, 3'h0, 5'h0b, 1'b1, BT_DATA, 4'h4);
    add(32'h0, C, 3'h2, 5'h14, 1'b1, BT_PRE, 4'h8);
    add(32'h400, C, 3'h2, 5'h14, 1'b1, BT_POST, 4'h8);
    add(32'h40, C, 3'h2, 5'h0b, 1'b1, BT_POST, 4'h4);
    add(32'h0, 6'h0f, 3'h0, 5'h14, 1'b0, BT_DATA, 4'h0);
    add(32'h0, 6'h13, 3'h0, 5'h14, 1'b0, BT_DATA, 4'h0);
    add(32'h0, 6'h1c, 3'h0, 5'h14, 1'b0, BT_DATA, 4'h0);
    rows[3].sb = D;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count reset", 32'h0, q);
    bus(1'b1, 8'h0c, 32'hffffffff);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'hffffffff);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reserved", 32'h00300cc9, q);
    bus(1'b1, OFS_COUNT, 32'hffffffff);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count width", 32'h00000fff, q);
    // Ordinary break cases: configure, issue one cycle, then check the request and the flags.
    foreach (rows[i]) begin
      bus(1'b1, OFS_CTRL, rows[i].ctrl);
      sa <= rows[i].sa;
      sb <= rows[i].sb;
      fire(rows[i].kind, rows[i].hits);
      chk("break_req", {31'h0, rows[i].req}, {31'h0, break_req});
      if (rows[i].req) chk("break_type", {30'h0, rows[i].typ}, {30'h0, break_type});
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl flags", rows[i].ctrl | {16'h0, rows[i].flags, 12'h0}, q);
    end
    // A flag survives a written one and only a written zero clears it.
    sa <= C;
    bus(1'b1, OFS_CTRL, 32'h0);
    fire(3'h0, 5'h14);
    bus(1'b1, OFS_CTRL, 32'h8000);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("flag kept", 32'h8000, q);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("flag cleared", 32'h0, q);
    // Chained mode: B alone and A alone are silent, B after A breaks.
    bus(1'b1, OFS_CTRL, 32'h8);
    fire(3'h0, 5'h0a);
    chk("chain b first", 32'h0, {31'h0, break_req});
    fire(3'h0, 5'h14);
    chk("chain a", 32'h0, {31'h0, break_req});
    fire(3'h0, 5'h0a);
    chk("chain b", 32'h1, {31'h0, break_req});
    // Counted breaks: three matches from a count of three, only the last one breaks.
    bus(1'b1, OFS_COUNT, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h1);
    fire(3'h0, 5'h0a);
    chk("count b1", 32'h0, {31'h0, break_req});
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count dec", 32'h2, q);
    fire(3'h0, 5'h0a);
    chk("count b2", 32'h0, {31'h0, break_req});
    fire(3'h0, 5'h0a);
    chk("count b3", 32'h1, {31'h0, break_req});
    // Trace: nothing is captured while disabled, the newest entry heads the queue.
    bus(1'b1, OFS_CTRL, 32'h0);
    brf({3'h1, 28'h0abcdef});
    bus(1'b0, OFS_TRACE, 32'h0);
    chk("trace off", 32'h0, {31'h0, q[31]});
    bus(1'b1, OFS_CTRL, 32'h800);
    brf({3'h5, 28'h1234567});
    brf({3'h2, 28'hfedcba9});
    bus(1'b0, OFS_TRACE, 32'h0);
    chk("trace head", 32'hafedcba9, q);
    bus(1'b0, OFS_TRACE, 32'h0);
    chk("trace reread", 32'h2fedcba9, q);
    brf({3'h5, 28'h0000abc});
    @(posedge hclk);
    mrst_n <= 1'b0;
    @(posedge hclk);
    mrst_n <= 1'b1;
    bus(1'b0, OFS_TRACE, 32'h0);
    chk("trace manual", 32'h50000abc, q);
    // A second power-on reset in mid-run clears the counter again.
    bus(1'b1, OFS_COUNT, 32'h5);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count rereset", 32'h0, q);
    wrap_up();
  end
endmodule : break_control_branch_trace_tb_top
